// *** src/mabp_pkg.sv ***
// package: constants and carrier types for the multiplexed bus port
`default_nettype none
package mabp_pkg;
  localparam int ADDR_W      = 20;
  localparam int AD_W        = 16;
  localparam int UPPER_LSB   = 16;
  localparam int UPPER_W     = 4;
  localparam int WAIT_STATES = 1;
  localparam logic [3:0] UPPER_IDLE = 4'h0;
  localparam logic [1:0] CNT_RST    = 2'h0;

  // cycle kinds as {mux bit0 level, byte-high enable level}
  typedef enum logic [1:0] {
    MABP_WORD  = 2'h0,
    MABP_EVEN  = 2'h1,
    MABP_ODD   = 2'h2,
    MABP_RFSH  = 2'h3
  } mabp_kind_t;

  typedef enum logic [4:0] {
    MABP_IDLE  = 5'h01,
    MABP_ADDR  = 5'h02,
    MABP_DATA  = 5'h04,
    MABP_WAIT  = 5'h08,
    MABP_DONE  = 5'h10
  } mabp_state_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic        write;
    mabp_kind_t  kind;
  } mabp_req_t;

  typedef struct packed {
    logic [15:0] adOut;
    logic [15:0] adOe;
    logic [3:0]  upperAddr;
    logic        addrLatch;
    logic        byteHighN;
    logic        xcvrEnN;
    logic        xcvrDirection;
  } mabp_pins_t;
endpackage
`default_nettype wire

// *** src/mabp_sync.sv ***
// three-stage synchroniser with agreement of the last two stages
`default_nettype none
module mabp_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // levels
  input  wire logic async,
  output var  logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } mabp_sync_st_t;

  mabp_sync_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.lvl = st_r.s3;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.lvl;
endmodule
`default_nettype wire

// *** src/mabp_port.sv ***
// multiplexed address/data bus port with coprocessor busy stall
// Function
// [R1] address bits 16-19 on upper outputs during address phase
// [R2] upper address outputs held low during data phase
// [R3] address bits 0-15 on shared lines during address phase; line 0 carries req.kind[1] instead of address bit 0
// [R4] data phase carries data; device drives on writes, partner on reads
// [R5] address latch strobe high during address phase
// [R6] byte-high enable low when upper data byte moves
// [R7] bit0 and byte-high enable encode word, even, odd, refresh
// [R8] byte-high enable pin also signals refresh cycles
// [R9] busy high halts coprocessor instruction execution
// [R10] execution resumes once busy is sampled low
// [R11] transceiver enable low only while data transfers
// [R12] direction high for transmit, low for receive
// [R13] bus clock is half the clock, changing on falling edges
// [R14] partner latches address while strobe high, holds it for the cycle
// [R15] coprocessor holds busy high while it works
`default_nettype none
module mabp_port (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // request from the execution unit
  input  wire logic                 reqValid,
  input  wire mabp_pkg::mabp_req_t  req,
  input  wire logic                 coprocInstr,
  output var  logic                 reqReady,
  output var  logic                 rdValid,
  output var  logic [15:0]          rdData,
  output var  logic                 execHalt,
  // bus pins
  input  wire logic [15:0]          adIn,
  output var  logic [15:0]          adOut,
  output var  logic [15:0]          adOe,
  output var  logic [3:0]           upperAddr,
  output var  logic                 addrLatch,
  output var  logic                 byteHighN,
  output var  logic                 xcvrEnN,
  output var  logic                 xcvrDirection,
  output var  logic                 busClock,
  // coprocessor
  input  wire logic                 coprocBusy
);
  typedef struct packed {
    mabp_pkg::mabp_state_t st;
    mabp_pkg::mabp_req_t   cur;
    mabp_pkg::mabp_pins_t  pins;
    logic [1:0]            cnt;
    logic                  ready;
    logic                  rdValid;
    logic [15:0]           rdData;
    logic                  halt;
  } mabp_port_st_t;

  mabp_port_st_t st_r, st_nxt;
  logic          busyLvl;
  logic          clkDiv_r;

  mabp_sync u_busy_sync (
    .clock (clock),
    .rstn  (rstn),
    .async (coprocBusy),
    .level (busyLvl)
  );

  // halved clock on falling edges so it is glitch free off a flop
  always_ff @(negedge clock or negedge rstn) begin
    if (!rstn) begin
      clkDiv_r <= 1'b0;
    end else begin
      clkDiv_r <= ~clkDiv_r; // [R13]
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdValid = 1'b0;
    // halt follows the synchronised busy only for coprocessor work
    st_nxt.halt = coprocInstr && busyLvl; // [R9] [R10]
    unique case (st_r.st)
      mabp_pkg::MABP_IDLE: begin
        st_nxt.ready = !st_nxt.halt;
        if (reqValid && st_r.ready) begin
          st_nxt.cur = req;
          st_nxt.ready = 1'b0;
          st_nxt.st = mabp_pkg::MABP_ADDR;
          st_nxt.pins.adOut = req.addr[15:0]; // [R3]
          st_nxt.pins.adOut[0] = req.kind[1]; // [R7]
          st_nxt.pins.adOe = '1;
          st_nxt.pins.upperAddr = req.addr[19:16]; // [R1]
          st_nxt.pins.addrLatch = 1'b1; // [R5]
          st_nxt.pins.byteHighN = req.kind[0]; // [R6] [R7] [R8]
          st_nxt.pins.xcvrDirection = req.write; // [R12]
        end
      end
      mabp_pkg::MABP_ADDR: begin
        st_nxt.pins.addrLatch = 1'b0;
        st_nxt.pins.upperAddr = mabp_pkg::UPPER_IDLE; // [R2]
        st_nxt.pins.xcvrEnN = (st_r.cur.kind == mabp_pkg::MABP_RFSH); // [R11]
        // [R4] device drives only on writes, partner on reads
        st_nxt.pins.adOe = st_r.cur.write ? '1 : '0;
        st_nxt.pins.adOut = st_r.cur.write ? st_r.cur.wdata : '0;
        st_nxt.cnt = mabp_pkg::CNT_RST;
        st_nxt.st = mabp_pkg::MABP_DATA;
      end
      mabp_pkg::MABP_DATA: begin
        if (st_r.cnt == 2'(mabp_pkg::WAIT_STATES)) begin
          st_nxt.st = mabp_pkg::MABP_WAIT;
        end else begin
          st_nxt.cnt = st_r.cnt + 2'h1;
        end
      end
      mabp_pkg::MABP_WAIT: begin
        if (!st_r.cur.write && st_r.cur.kind != mabp_pkg::MABP_RFSH) begin
          st_nxt.rdValid = 1'b1;
          st_nxt.rdData = adIn; // [R4]
        end
        st_nxt.pins.xcvrEnN = 1'b1; // [R11]
        st_nxt.pins.adOe = '0;
        st_nxt.pins.byteHighN = 1'b1;
        st_nxt.st = mabp_pkg::MABP_DONE;
      end
      mabp_pkg::MABP_DONE: begin
        st_nxt.pins.xcvrDirection = 1'b0;
        st_nxt.ready = !st_nxt.halt;
        st_nxt.st = mabp_pkg::MABP_IDLE;
      end
      default: begin
        st_nxt.st = mabp_pkg::MABP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.st <= mabp_pkg::MABP_IDLE;
      st_r.pins.byteHighN <= 1'b1;
      st_r.pins.xcvrEnN <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reqReady      = st_r.ready;
  assign rdValid       = st_r.rdValid;
  assign rdData        = st_r.rdData;
  assign execHalt      = st_r.halt;
  assign adOut         = st_r.pins.adOut;
  assign adOe          = st_r.pins.adOe;
  assign upperAddr     = st_r.pins.upperAddr;
  assign addrLatch     = st_r.pins.addrLatch;
  assign byteHighN     = st_r.pins.byteHighN;
  assign xcvrEnN       = st_r.pins.xcvrEnN;
  assign xcvrDirection = st_r.pins.xcvrDirection;
  assign busClock      = clkDiv_r;

  sequence seqAddr;
    addrLatch && st_r.st == mabp_pkg::MABP_ADDR;
  endsequence
  sequence seqData;
    !addrLatch && upperAddr == 4'h0;
  endsequence

  chk_upper_addr_out: assert property (@(posedge clock) disable iff (!rstn)
    $rose(addrLatch) |-> upperAddr == st_r.cur.addr[19:16]) // [R1]
    else $error("upper address wrong in address phase");
  chk_upper_zero_data: assert property (@(posedge clock) disable iff (!rstn)
    seqAddr |=> seqData) // [R2]
    else $error("upper address not low in data phase");
  chk_low_addr_out: assert property (@(posedge clock) disable iff (!rstn)
    addrLatch |-> adOut[15:1] == st_r.cur.addr[15:1] && adOe == 16'hffff) // [R3]
    else $error("low address missing in address phase");
  chk_write_drive: assert property (@(posedge clock) disable iff (!rstn)
    !xcvrEnN |-> (adOe == (st_r.cur.write ? 16'hffff : 16'h0000))) // [R4]
    else $error("data drive direction wrong");
  chk_latch_pulse: assert property (@(posedge clock) disable iff (!rstn)
    $rose(addrLatch) |=> !addrLatch ##3 !addrLatch) // [R5]
    else $error("latch strobe not a single address phase");
  chk_kind_code: assert property (@(posedge clock) disable iff (!rstn)
    addrLatch |-> {adOut[0], byteHighN} == st_r.cur.kind) // [R7]
    else $error("cycle kind encoding wrong");
  chk_refresh_no_xfer: assert property (@(posedge clock) disable iff (!rstn)
    (addrLatch && st_r.cur.kind == mabp_pkg::MABP_RFSH) |=> xcvrEnN [*3]) // [R11]
    else $error("transceiver enabled in refresh");
  chk_xcvr_window: assert property (@(posedge clock) disable iff (!rstn)
    !xcvrEnN |-> st_r.st inside {mabp_pkg::MABP_DATA, mabp_pkg::MABP_WAIT}) // [R11]
    else $error("transceiver enabled outside data phase");
  chk_direction: assert property (@(posedge clock) disable iff (!rstn)
    addrLatch |-> xcvrDirection == st_r.cur.write) // [R12]
    else $error("direction does not match transfer");
  chk_busy_halt: assert property (@(posedge clock) disable iff (!rstn)
    (coprocInstr && coprocBusy) [*6] |-> execHalt && !reqReady) // [R9]
    else $error("busy did not halt execution");
  chk_busy_resume: assert property (@(posedge clock) disable iff (!rstn)
    (!coprocBusy) [*6] |-> !execHalt) // [R10]
    else $error("execution not resumed after busy low");
  chk_bus_clock: assert property (@(negedge clock) disable iff (!rstn)
    $past(rstn) |-> busClock != $past(busClock)) // [R13]
    else $error("bus clock not halved");
endmodule
`default_nettype wire

// *** test/mabp_partner.sv ***
// partner model: address latch, read data pattern and coprocessor
`default_nettype none
module mabp_partner (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // bus pins
  input  wire logic [15:0] adOut,
  input  wire logic [3:0]  upperAddr,
  input  wire logic        addrLatch,
  input  wire logic        xcvrEnN,
  input  wire logic        xcvrDirection,
  output wire logic [15:0] adIn,
  output var  logic [19:0] latched,
  // coprocessor
  input  wire logic [7:0]  busyLen,
  output wire logic        coprocBusy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  busyCnt;
  logic [15:0] lastAd;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      latched <= '0;
      busyCnt <= '0;
      lastAd <= '0;
    end else begin
      if (addrLatch)
        latched <= {upperAddr, adOut};
      if (busyLen != 8'h00)
        busyCnt <= busyLen;
      else if (busyCnt != 8'h00)
        busyCnt <= busyCnt - 8'h01;
      lastAd <= adIn;
    end
  end
  assign coprocBusy = (busyCnt != 8'h00);
  // released lines toggle so a stale sample never matches
  assign adIn = (!xcvrEnN && !xcvrDirection) ?
                latched[15:0] ^ 16'h5a5a : ~lastAd;
endmodule
`default_nettype wire

// *** test/mabp_port_tb_top.sv ***
// self-checking bench for the multiplexed bus port
`default_nettype none
`define CHK(g, e) checkVal(32'(g), 32'(e))
module mabp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rstn = 0, reqValid = 0, coprocInstr = 0;
  logic reqReady, rdValid, execHalt, addrLatch, byteHighN;
  logic xcvrEnN, xcvrDirection, busClock, coprocBusy;
  logic [15:0] rdData, adIn, adOut, adOe;
  logic [3:0]  upperAddr;
  logic [19:0] latched;
  logic [7:0]  busyLen = 0;
  mabp_pkg::mabp_req_t req = '0;
  int nErrors = 0, nCompared = 0;

  always #50 clock = ~clock;

  mabp_port mabp_port_inst (.clock(clock), .rstn(rstn),
    .reqValid(reqValid), .req(req), .coprocInstr(coprocInstr),
    .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
    .execHalt(execHalt), .adIn(adIn), .adOut(adOut), .adOe(adOe),
    .upperAddr(upperAddr), .addrLatch(addrLatch),
    .byteHighN(byteHighN), .xcvrEnN(xcvrEnN),
    .xcvrDirection(xcvrDirection), .busClock(busClock),
    .coprocBusy(coprocBusy));
  mabp_partner mabp_partner_inst (.clock(clock), .rstn(rstn),
    .adOut(adOut), .upperAddr(upperAddr), .addrLatch(addrLatch),
    .xcvrEnN(xcvrEnN), .xcvrDirection(xcvrDirection), .adIn(adIn),
    .latched(latched), .busyLen(busyLen), .coprocBusy(coprocBusy));

  task automatic checkVal(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e) begin
      nErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask

  task automatic runCycle(input logic [19:0] a, input logic [15:0] d,
                          input logic w, input mabp_pkg::mabp_kind_t k);
    logic [15:0] lo;
    logic        rd;
    int          i;
    lo = {a[15:1], k[1]};
    rd = !w && k != mabp_pkg::MABP_RFSH;
    i = 0;
    while (reqReady !== 1'b1 && i < 50) begin
      step(1);
      i++;
    end
    // a port that never becomes ready counts as a mismatch
    if (reqReady !== 1'b1)
      nErrors++;
    req = '{addr: a, wdata: d, write: w, kind: k};
    reqValid = 1'b1;
    step(1);
    reqValid = 1'b0;
    `CHK(addrLatch, 1'b1);
    `CHK(adOut, lo);
    `CHK(upperAddr, a[19:16]);
    `CHK({adOut[0], byteHighN}, k);
    `CHK(xcvrDirection, w);
    step(1);
    `CHK(addrLatch, 1'b0);
    `CHK(upperAddr, 4'h0);
    `CHK(xcvrEnN, k == mabp_pkg::MABP_RFSH);
    `CHK(adOe, w ? 16'hffff : 16'h0000);
    `CHK(byteHighN, k[0]);
    if (w)
      `CHK(adOut, d);
    // data phase runs two counted cycles plus the sampling cycle
    step(2);
    `CHK(xcvrEnN, k == mabp_pkg::MABP_RFSH);
    `CHK(upperAddr, 4'h0);
    step(1);
    `CHK(xcvrEnN, 1'b1);
    `CHK(rdValid, rd);
    if (rd)
      `CHK(rdData, lo ^ 16'h5a5a);
  endtask

  task automatic testKinds;
    for (int k = 0; k < 4; k++) begin
      runCycle(20'hab35c + 20'(k), 16'h0000, 1'b0,
               mabp_pkg::mabp_kind_t'(k));
      runCycle(20'h5ca73 - 20'(k), 16'hc3e1 + 16'(k), 1'b1,
               mabp_pkg::mabp_kind_t'(k));
    end
    $display("test kinds done");
  endtask

  task automatic testHalt;
    int i;
    coprocInstr = 1'b1;
    busyLen = 8'd12;
    step(1);
    busyLen = 8'h00;
    step(5);
    `CHK(execHalt, 1'b1);
    `CHK(reqReady, 1'b0);
    i = 0;
    while (execHalt !== 1'b0 && i < 30) begin
      step(1);
      i++;
    end
    `CHK(execHalt, 1'b0);
    coprocInstr = 1'b0;
    runCycle(20'hf0001, 16'h1234, 1'b1, mabp_pkg::MABP_WORD);
    $display("test halt done");
  endtask

  task automatic testClock;
    logic b;
    b = busClock;
    // one falling edge lies between samples, so it must toggle each time
    for (int i = 0; i < 4; i++) begin
      step(1);
      `CHK(busClock, !b);
      b = busClock;
    end
    $display("test clock done");
  endtask

  task automatic completeRun;
    $display("compared %0d mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    step(10);
    rstn = 1'b1;
    step(2);
    testKinds();
    testHalt();
    testClock();
    completeRun();
  end

  initial begin
    #(600 * 100);
    nErrors++;
    completeRun();
  end
endmodule
`undef CHK
`default_nettype wire
